// *** analog_window_trigger.sv ***
// Threshold window trigger with APB register access and per-channel front-end settings.
// Assumes sample codes arrive synchronous to pclk, offset binary, qualified by sample_valid.
`timescale 1ns/10ps
`default_nettype none

module analog_window_trigger (
  // Clock and reset
  input  wire logic                                          pclk,
  input  wire logic                                          presetn,
  // APB slave
  input  wire logic                                          psel,
  input  wire logic                                          penable,
  input  wire logic                                          pwrite,
  input  wire logic [11:0]                                   paddr,
  input  wire logic [31:0]                                   pwdata,
  output logic                                               pready,
  output logic                                               pslverr,
  output logic [31:0]                                        prdata,
  // Samples and external trigger
  input  wire logic                                          fine_variant,
  input  wire logic                                          sample_valid,
  input  wire logic [window_trigger_pkg::CODE_W-1:0]         direct_trigger_pin,
  input  wire logic [window_trigger_pkg::NUM_CH-1:0][window_trigger_pkg::CODE_W-1:0] gain_amplifier,
  input  wire logic                                          ext_trig,
  // Trigger outputs
  output logic                                               analog_trig,
  output logic                                               start_trig,
  output logic                                               irq,
  // Per-channel front-end settings
  output logic [window_trigger_pkg::NUM_CH-1:0][2:0]         ch_range,
  output logic [window_trigger_pkg::NUM_CH-1:0]              ch_ac_coupled
);

  window_trigger_pkg::trig_state_s st_r;
  window_trigger_pkg::trig_state_s st_nxt;

  logic [window_trigger_pkg::CODE_W-1:0] sig;
  logic [window_trigger_pkg::CODE_W-1:0] lo_lvl;
  logic [window_trigger_pkg::CODE_W-1:0] hi_lvl;
  logic [window_trigger_pkg::CODE_W-1:0] step_mask;
  logic [1:0]                            ch_sel;
  logic                                  setup;
  logic                                  access;
  logic                                  wr;
  logic                                  rd;
  logic                                  below;
  logic                                  above;
  logic                                  cmp;
  logic [2:0]                            evt;
  logic [2:0]                            clr;

  assign ch_sel    = st_r.ctrl[window_trigger_pkg::CTRL_CH_LSB +: 2];
  // Source selection feeds the single comparator.
  assign sig       = st_r.ctrl[window_trigger_pkg::CTRL_SRC_PIN] ?
                     direct_trigger_pin : gain_amplifier[ch_sel];
  // Coarse parts resolve 256 levels over the source's span.
  assign step_mask = fine_variant ? window_trigger_pkg::FINE_MASK
                                  : window_trigger_pkg::COARSE_MASK;
  assign lo_lvl    = st_r.lower & step_mask;
  assign hi_lvl    = st_r.upper & step_mask;
  assign below     = sig < lo_lvl;
  assign above     = sig > hi_lvl;
  assign setup     = psel && !penable;
  assign access    = psel && penable && st_r.pready;
  assign wr        = access && pwrite;
  assign rd        = access && !pwrite;

  always_comb begin
    st_nxt  = st_r;
    cmp     = st_r.level;
    evt     = window_trigger_pkg::EVT_RST;
    clr     = window_trigger_pkg::EVT_RST;

    // Bus write side; the answer comes one cycle after setup.
    st_nxt.pready  = setup;
    st_nxt.pslverr = 1'b0;
    if (wr) begin
      unique case (paddr)
        window_trigger_pkg::OFS_CTRL:   st_nxt.ctrl  = pwdata[7:0];
        window_trigger_pkg::OFS_LOWER:  st_nxt.lower = pwdata[11:0];
        window_trigger_pkg::OFS_UPPER:  st_nxt.upper = pwdata[11:0];
        window_trigger_pkg::OFS_CHCFG:  st_nxt.chcfg = pwdata[15:0];
        window_trigger_pkg::OFS_SWTRIG: evt[window_trigger_pkg::ST_SOFT] = pwdata[0];
        window_trigger_pkg::OFS_MASK:   st_nxt.mask  = pwdata[2:0];
        window_trigger_pkg::OFS_STATUS: ;
        default:                        ;
      endcase
    end
    // Only the bits handed out by this read are cleared, so an event that
    // lands between setup and access stays pending for the next read.
    if (rd && paddr == window_trigger_pkg::OFS_STATUS) begin
      clr = st_r.prdata[2:0];
    end

    // Read data and error are prepared during setup so they leave a flop.
    if (setup) begin
      st_nxt.prdata = 32'h0000_0000;
      unique case (paddr)
        window_trigger_pkg::OFS_CTRL:   st_nxt.prdata[7:0]   = st_r.ctrl;
        window_trigger_pkg::OFS_LOWER:  st_nxt.prdata[11:0]  = st_r.lower;
        window_trigger_pkg::OFS_UPPER:  st_nxt.prdata[11:0]  = st_r.upper;
        window_trigger_pkg::OFS_CHCFG:  st_nxt.prdata[15:0]  = st_r.chcfg;
        window_trigger_pkg::OFS_SWTRIG: ;
        window_trigger_pkg::OFS_STATUS: begin
          st_nxt.prdata[2:0] = st_r.status;
          st_nxt.prdata[window_trigger_pkg::ST_LEVEL] = st_r.level;
        end
        window_trigger_pkg::OFS_MASK:   st_nxt.prdata[2:0]   = st_r.mask;
        default:                        st_nxt.pslverr = 1'b1;
      endcase
    end

    // Comparator, evaluated once per new sample.
    if (sample_valid) begin
      unique case (window_trigger_pkg::trig_mode_e'(st_r.ctrl[2:0]))
        window_trigger_pkg::MODE_BELOW_LOW:  cmp = below;
        window_trigger_pkg::MODE_ABOVE_HIGH: cmp = above;
        window_trigger_pkg::MODE_INSIDE:     cmp = !below && !above;
        window_trigger_pkg::MODE_HIGH_HYST: begin
          // Held until the signal drops under the lower level, then rearmed.
          unique case (st_r.hyst)
            window_trigger_pkg::HY_ARMED: if (above) begin
              cmp         = 1'b1;
              st_nxt.hyst = window_trigger_pkg::HY_FIRED;
            end else begin
              cmp = 1'b0;
            end
            window_trigger_pkg::HY_FIRED: if (below) begin
              cmp         = 1'b0;
              st_nxt.hyst = window_trigger_pkg::HY_ARMED;
            end
          endcase
        end
        window_trigger_pkg::MODE_LOW_HYST: begin
          // Mirror image: fires under lower, rearms over upper.
          unique case (st_r.hyst)
            window_trigger_pkg::HY_ARMED: if (below) begin
              cmp         = 1'b1;
              st_nxt.hyst = window_trigger_pkg::HY_FIRED;
            end else begin
              cmp = 1'b0;
            end
            window_trigger_pkg::HY_FIRED: if (above) begin
              cmp         = 1'b0;
              st_nxt.hyst = window_trigger_pkg::HY_ARMED;
            end
          endcase
        end
        default: cmp = 1'b0;
      endcase
    end
    // A disabled trigger or any write to the control register rearms the hysteresis tracker.
    if (!st_r.ctrl[window_trigger_pkg::CTRL_EN] ||
        (wr && paddr == window_trigger_pkg::OFS_CTRL)) begin
      cmp         = 1'b0;
      st_nxt.hyst = window_trigger_pkg::HY_ARMED;
    end
    st_nxt.level = cmp;

    // Start sources: threshold rising edge, software write, external rising edge.
    evt[window_trigger_pkg::ST_ANALOG] = cmp && !st_r.level;
    st_nxt.ext_d = ext_trig;
    evt[window_trigger_pkg::ST_EXT] = st_r.ctrl[window_trigger_pkg::CTRL_EXT_EN] &&
                                      ext_trig && !st_r.ext_d;
    st_nxt.start = |evt;

    // Set wins over a clearing read in the same cycle.
    st_nxt.status = (st_r.status & ~clr) | evt;
    st_nxt.irq    = |(st_nxt.status & st_r.mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r.ctrl    <= window_trigger_pkg::CTRL_RST;
      st_r.lower   <= window_trigger_pkg::LOWER_RST;
      st_r.upper   <= window_trigger_pkg::UPPER_RST;
      st_r.chcfg   <= window_trigger_pkg::CHCFG_RST;
      st_r.status  <= window_trigger_pkg::EVT_RST;
      st_r.mask    <= window_trigger_pkg::EVT_RST;
      st_r.hyst    <= window_trigger_pkg::HY_ARMED;
      st_r.level   <= 1'b0;
      st_r.ext_d   <= 1'b0;
      st_r.start   <= 1'b0;
      st_r.irq     <= 1'b0;
      st_r.pready  <= 1'b0;
      st_r.pslverr <= 1'b0;
      st_r.prdata  <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pready      = st_r.pready;
  assign pslverr     = st_r.pslverr;
  assign prdata      = st_r.prdata;
  assign analog_trig = st_r.level;
  assign start_trig  = st_r.start;
  assign irq         = st_r.irq;

  // Each channel's nibble: range code in bits 2:0, AC coupling in bit 3.
  for (genvar i = 0; i < window_trigger_pkg::NUM_CH; i++) begin : g_ch
    assign ch_range[i]      = st_r.chcfg[i*window_trigger_pkg::CHCFG_W +: 3];
    assign ch_ac_coupled[i] = st_r.chcfg[i*window_trigger_pkg::CHCFG_W + 3];
  end

endmodule : analog_window_trigger

`default_nettype wire

// *** scan_burst_model.sv ***
// Timing-section model that consumes the start trigger and runs a scan burst.
// Assumes start_trig is a one-cycle pulse synchronous to pclk.
`timescale 1ns/10ps
`default_nettype none
module scan_burst_model #(parameter int N_SCANS = 4) (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Trigger in, burst count out
  input  wire logic       start_trig,
  output logic [7:0]      scans_left
);
  // A trigger in mid-burst restarts the count, as a retriggerable section would.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) scans_left <= 8'h00;
    else if (start_trig) scans_left <= 8'(N_SCANS);
    else if (scans_left != 8'h00) scans_left <= scans_left - 8'h01;
  end
endmodule : scan_burst_model
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench: APB master, sample driver and a scoreboard of read results.
// Assumes the slave answers every transfer; each wait is bounded anyway.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, fine_variant;
  logic             sample_valid, ext_trig, analog_trig, start_trig, irq, lvl, src;
  logic [11:0]      paddr, pin, lo, hi;
  logic [31:0]      pwdata, prdata, rnd;
  logic [3:0][11:0] gain;
  logic [3:0][2:0]  ch_range;
  logic [3:0]       ch_ac_coupled;
  logic [7:0]       scans_left;
  logic [2:0]       mode, ev, mask;
  logic [1:0]       ch;
  logic [33:0]      exp_q[$];
  int               num_errors = 0;
  int               n_compared = 0;
  analog_window_trigger dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .fine_variant(fine_variant), .sample_valid(sample_valid),
    .direct_trigger_pin(pin), .gain_amplifier(gain), .ext_trig(ext_trig),
    .analog_trig(analog_trig), .start_trig(start_trig), .irq(irq), .ch_range(ch_range),
    .ch_ac_coupled(ch_ac_coupled));
  scan_burst_model #(.N_SCANS(4)) u_burst (.pclk(pclk), .presetn(presetn),
    .start_trig(start_trig), .scans_left(scans_left));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  task automatic conclude();
    if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  task automatic chk(input string what, input logic [33:0] seen, input logic [33:0] want);
    n_compared++;
    if (seen !== want) begin
      num_errors++;
      $display("FAIL %s at %h expected %h seen %h", what, paddr, want, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      conclude();
    end
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  // Status read: live level in bit 8, sticky events below, irq from events and mask.
  task automatic rds();
    rd(12'h014, {1'b0, |(ev & mask), 23'h0, lvl, 5'h0, ev});
    ev = 3'h0;
  endtask : rds
  task automatic smp();
    logic [3:0][11:0] g;
    logic [11:0]      s, l, h;
    logic             n;
    logic             e;
    rnd = nxt(rnd);
    g = {rnd[23:12], rnd[11:0], ~rnd[23:12], rnd[31:20]};
    s = src ? rnd[11:0] : g[ch];
    l = lo & (fine_variant ? 12'hfff : 12'hff0);
    h = hi & (fine_variant ? 12'hfff : 12'hff0);
    case (mode)
      3'h0: n = s < l;
      3'h1: n = s > h;
      3'h2: n = s >= l && s <= h;
      3'h3: n = lvl ? s >= l : s > h;
      3'h4: n = lvl ? s <= h : s < l;
      default: n = 1'b0;
    endcase
    e = n && !lvl;
    if (e) ev[0] = 1'b1;
    lvl = n;
    @(posedge pclk);
    {pin, gain, sample_valid} <= {rnd[11:0], g, 1'b1};
    @(posedge pclk);
    sample_valid <= 1'b0;
    @(posedge pclk);
    chk("start", {33'h0, start_trig}, {33'h0, e});
    rds();
    chk("trig", {33'h0, analog_trig}, {33'h0, lvl});
  endtask : smp
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite)
      chk("read", {pslverr, irq, prdata}, exp_q.pop_front());
  initial begin
    rnd = 32'h27c57224;
    {ev, lvl, mask, src, ch, mode, lo, hi} = '0;
    {psel, penable, pwrite, paddr, pwdata, pin, gain} = '0;
    {sample_valid, ext_trig, fine_variant, presetn} = 4'b0010;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h000, 34'h0);
    rd(12'h004, 34'h0);
    rd(12'h008, 34'hfff);
    rd(12'h00c, 34'h0);
    rd(12'h010, 34'h0);
    rd(12'h018, 34'h0);
    rds();
    rd(12'h01c, {1'b1, 33'h0});
    rnd = nxt(rnd);
    apb(1'b1, 12'h00c, {16'h0, rnd[15:0]});
    rd(12'h00c, {18'h0, rnd[15:0]});
    chk("chcfg", {18'h0, ch_ac_coupled[3], ch_range[3], ch_ac_coupled[2], ch_range[2],
      ch_ac_coupled[1], ch_range[1], ch_ac_coupled[0], ch_range[0]}, {18'h0, rnd[15:0]});
    for (int f = 0; f < 2; f++) begin
      fine_variant <= f[0];
      for (int m = 0; m < 6; m++) begin
        rnd = nxt(rnd);
        {lo, hi, src, ch, mask} = {rnd[31:8], rnd[7:5], rnd[4:2]};
        mode = m[2:0];
        apb(1'b1, 12'h004, {20'h0, lo});
        apb(1'b1, 12'h008, {20'h0, hi});
        apb(1'b1, 12'h018, {29'h0, mask});
        apb(1'b1, 12'h000, {24'h0, 2'b01, ch, src, mode});
        lvl = 1'b0;
        repeat (10) smp();
      end
    end
    apb(1'b1, 12'h010, 32'h1);
    @(posedge pclk);
    chk("start", {33'h0, start_trig}, 34'h1);
    @(posedge pclk);
    chk("scans", {26'h0, scans_left}, 34'h4);
    ev[1] = 1'b1;
    rds();
    apb(1'b1, 12'h000, 32'h80);
    lvl = 1'b0;
    ext_trig <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("start", {33'h0, start_trig}, 34'h1);
    @(posedge pclk);
    ev[2] = 1'b1;
    rds();
    ext_trig <= 1'b0;
    apb(1'b1, 12'h000, 32'h0);
    ext_trig <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("start", {33'h0, start_trig}, 34'h0);
    @(posedge pclk);
    rds();
    repeat (4) @(posedge pclk);
    conclude();
  end
endmodule : testbench
`default_nettype wire

// *** trig_props.sv ***
// Port-level assertions for the window trigger, bound into its top module.
// Assumes one clock, pclk, and the active-low asynchronous reset presetn.
`timescale 1ns/10ps
`default_nettype none
module trig_props (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  // Trigger and settings
  input wire logic        sample_valid,
  input wire logic        analog_trig,
  input wire logic        start_trig,
  input wire logic        irq,
  input wire logic [window_trigger_pkg::NUM_CH-1:0][2:0] ch_range,
  input wire logic [window_trigger_pkg::NUM_CH-1:0]      ch_ac_coupled
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_reads_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("bad error response");
  a_start_on_rise: assert property ($rose(analog_trig) |-> start_trig)
    else $error("no start pulse on trigger rise");
  a_rise_needs_sample: assert property ($rose(analog_trig) |-> $past(sample_valid))
    else $error("trigger rose without a sample");
  a_fall_has_cause: assert property ($fell(analog_trig) |->
    $past(sample_valid) || $past(pready && pwrite))
    else $error("trigger fell without a cause");
  a_quiet_after_reset: assert property (!$past(presetn) |-> !analog_trig && !start_trig
    && !irq && ch_range == '0 && ch_ac_coupled == '0)
    else $error("outputs not cleared by reset");
  a_range_by_write: assert property (!$stable(ch_range) |-> $past(pready && pwrite))
    else $error("range changed without a write");
  a_coupling_by_write: assert property (!$stable(ch_ac_coupled) |-> $past(pready && pwrite))
    else $error("coupling changed without a write");
endmodule : trig_props
bind analog_window_trigger trig_props u_props (.pclk, .presetn, .psel, .penable, .pwrite,
  .pready, .pslverr, .prdata, .sample_valid, .analog_trig, .start_trig, .irq, .ch_range,
  .ch_ac_coupled);
`default_nettype wire

// *** window_trigger_pkg.sv ***
// Constants, register map and types for the threshold window trigger.
// Assumes a 32-bit APB slave port at 20 MHz and 12-bit offset-binary sample codes.
//
// Summary of operation
// - Comparator input is the direct trigger pin or one channel's amplifier output.
// - Direct pin levels span plus/minus ten volts in coarse or fine steps.
// - Channel source levels span its full scale in 256 or 4096 steps.
// - Lower and upper thresholds are held and written independently.
// - Below-low mode triggers while signal is under the lower threshold.
// - Above-high mode triggers while signal exceeds the upper threshold.
// - Inside-region mode triggers while signal lies between both thresholds.
// - High-hysteresis triggers rising above upper, lower sets the hysteresis level.
// - Low-hysteresis triggers falling below lower, upper sets the hysteresis level.
// - The result is an internal digital trigger for all timing sections.
// - Software trigger and external digital trigger can also start a sequence.
// - Each channel holds its own range, one of eight bipolar ranges.
// - Each channel holds its own AC or DC coupling selection.

package window_trigger_pkg;

  localparam int          NUM_CH      = 4;
  localparam int          CODE_W      = 12;
  localparam int          CHCFG_W     = 4;

  // Register byte offsets.
  localparam logic [11:0] OFS_CTRL    = 12'h000;
  localparam logic [11:0] OFS_LOWER   = 12'h004;
  localparam logic [11:0] OFS_UPPER   = 12'h008;
  localparam logic [11:0] OFS_CHCFG   = 12'h00c;
  localparam logic [11:0] OFS_SWTRIG  = 12'h010;
  localparam logic [11:0] OFS_STATUS  = 12'h014;
  localparam logic [11:0] OFS_MASK    = 12'h018;

  // Field positions.
  localparam int          CTRL_MODE_LSB = 0;
  localparam int          CTRL_SRC_PIN  = 3;
  localparam int          CTRL_CH_LSB   = 4;
  localparam int          CTRL_EN       = 6;
  localparam int          CTRL_EXT_EN   = 7;
  localparam int          ST_ANALOG     = 0;
  localparam int          ST_SOFT       = 1;
  localparam int          ST_EXT        = 2;
  localparam int          ST_LEVEL      = 8;

  // Reset values.
  localparam logic [7:0]  CTRL_RST    = 8'h00;
  localparam logic [11:0] LOWER_RST   = 12'h000;
  localparam logic [11:0] UPPER_RST   = 12'hfff;
  localparam logic [15:0] CHCFG_RST   = 16'h0000;
  localparam logic [2:0]  EVT_RST     = 3'h0;

  // Coarse variant keeps only the top eight bits of each threshold.
  localparam logic [11:0] COARSE_MASK = 12'hff0;
  localparam logic [11:0] FINE_MASK   = 12'hfff;

  typedef enum logic [2:0] {
    MODE_BELOW_LOW  = 3'h0,
    MODE_ABOVE_HIGH = 3'h1,
    MODE_INSIDE     = 3'h2,
    MODE_HIGH_HYST  = 3'h3,
    MODE_LOW_HYST   = 3'h4
  } trig_mode_e;

  typedef enum logic [0:0] {
    HY_ARMED = 1'b0,
    HY_FIRED = 1'b1
  } hyst_e;

  typedef struct packed {
    logic [7:0]                ctrl;
    logic [CODE_W-1:0]         lower;
    logic [CODE_W-1:0]         upper;
    logic [NUM_CH*CHCFG_W-1:0] chcfg;
    logic [2:0]                status;
    logic [2:0]                mask;
    hyst_e                     hyst;
    logic                      level;
    logic                      ext_d;
    logic                      start;
    logic                      irq;
    logic                      pready;
    logic                      pslverr;
    logic [31:0]               prdata;
  } trig_state_s;

endpackage : window_trigger_pkg
